/* File: test_windowed_watchdog_timer.sv */
// Purpose: Register-level test of the watchdog
// Assumes: Count clocks made from aclk, 8 and 16 cycle periods
// Notes: One bus transfer at a time
`timescale 1ns/1ps
`include "wwt_map.svh"
module test_windowed_watchdog_timer;
	localparam int LIMIT = 60000;
	logic aclk = 1'h0, aresetn = 1'h0, rc = 1'h0, osc = 1'h0, rc_on = 1'h0, osc_on = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0, d;
	logic [1:0] r;
	wire logic awready, wready, bvalid, arready, rvalid, wd_chip_reset, irq;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	int cyc = 0, pulses = 0, err_count = 0, checks_done = 0, t0;

	// ****************************************
	// Device, clock and count clocks
	// ****************************************
	wwt_top u_wwt_top (.aclk(aclk), .aresetn(aresetn), .internal_rc_clock(rc), .dedicated_wd_oscillator(osc),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .wd_chip_reset(wd_chip_reset), .irq(irq));
	always #25 aclk = ~aclk;
	// Count clocks, pulse count and timeout
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		rc <= rc_on & cyc[2];
		osc <= osc_on & cyc[3];
		if (wd_chip_reset === 1'h1) pulses <= pulses + 1;
		if (cyc == LIMIT) begin
			err_count++;
			final_report;
		end
	end

	// ****************************************
	// Report, check and bus tasks
	// ****************************************
	task final_report;
		$display("Mismatches %0d, checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// Each channel released at its own ready
	task wr(input logic [4:0] a, input logic [31:0] v);
		logic aw_left, w_left;
		aw_left = 1'h1;
		w_left = 1'h1;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (aw_left || w_left) begin
			@(posedge aclk);
			if (aw_left && awready === 1'h1) begin
				aw_left = 1'h0;
				awvalid <= 1'h0;
			end
			if (w_left && wready === 1'h1) begin
				w_left = 1'h0;
				wvalid <= 1'h0;
			end
		end
		bready <= 1'h1;
		do @(posedge aclk); while (bvalid !== 1'h1);
		r = bresp;
		bready <= 1'h0;
	endtask
	task rd(input logic [4:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(posedge aclk); while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	task rc_chk(input string n, input logic [4:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, d);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rc_chk("mode", `WWT_OFS_MODE, 32'h0);
		chk("rd_okay", `WWT_RESP_OKAY, r);
		rc_chk("timeout", `WWT_OFS_TIMEOUT, 32'hFFFFFF);
		rc_chk("window", `WWT_OFS_WINDOW, 32'hFFFFFF);
		rc_chk("warn", `WWT_OFS_WARN, 32'h0);
		rc_chk("count", `WWT_OFS_COUNT, 32'hFFFFFF);
		rd(5'h02);
		chk("rd_err", `WWT_RESP_SLVERR, r);
		wr(5'h05, 32'h1);
		chk("wr_err", `WWT_RESP_SLVERR, r);
		wr(`WWT_OFS_TIMEOUT, 32'h10);
		chk("wr_okay", `WWT_RESP_OKAY, r);
		rc_chk("timeout_min", `WWT_OFS_TIMEOUT, 32'h100);
		wr(`WWT_OFS_MASK, 32'h7);
		wr(`WWT_OFS_WARN, 32'hF0);
		rc_on <= 1'h1;
		wr(`WWT_OFS_MODE, 32'h3);
		wr(`WWT_OFS_MODE, 32'h2);
		rc_chk("set_only", `WWT_OFS_MODE, 32'h3);
		do rd(`WWT_OFS_COUNT); while (d > 32'hF8);
		wr(`WWT_OFS_FEED, 32'hAA);
		wr(`WWT_OFS_FEED, 32'h55);
		rd(`WWT_OFS_COUNT);
		chk("reload", 32'h1, d >= 32'hFE && d <= 32'h100);
		do @(posedge aclk); while (irq !== 1'h1);
		rd(`WWT_OFS_COUNT);
		chk("warn_point", 32'h1, d >= 32'hEE && d <= 32'hF0);
		rc_chk("st_warn", `WWT_OFS_STATUS, 32'h1);
		wr(`WWT_OFS_STATUS, 32'h1);
		repeat (2) @(posedge aclk);
		chk("irq_clear", 32'h0, irq);
		wr(`WWT_OFS_MASK, 32'h0);
		do rd(`WWT_OFS_STATUS); while (d[1] !== 1'h1);
		chk("irq_masked", 32'h0, irq);
		chk("no_pulse", 32'h0, pulses);
		rc_chk("mode_tout", `WWT_OFS_MODE, 32'h2);
		wr(`WWT_OFS_MASK, 32'h7);
		repeat (2) @(posedge aclk);
		chk("irq_unmask", 32'h1, irq);
		wr(`WWT_OFS_STATUS, 32'h7);
		wr(`WWT_OFS_WARN, 32'h10);
		wr(`WWT_OFS_WINDOW, 32'h80);
		wr(`WWT_OFS_MODE, 32'h7);
		wr(`WWT_OFS_FEED, 32'hAA);
		wr(`WWT_OFS_FEED, 32'h55);
		rc_chk("st_early", `WWT_OFS_STATUS, 32'h4);
		rc_chk("mode_early", `WWT_OFS_MODE, 32'h6);
		wr(`WWT_OFS_STATUS, 32'h7);
		wr(`WWT_OFS_MODE, 32'h7);
		do rd(`WWT_OFS_COUNT); while (d > 32'h7F);
		wr(`WWT_OFS_FEED, 32'hAA);
		wr(`WWT_OFS_FEED, 32'h55);
		rc_chk("st_in_win", `WWT_OFS_STATUS, 32'h0);
		rd(`WWT_OFS_COUNT);
		chk("win_reload", 32'h1, d >= 32'hFE);
		wr(`WWT_OFS_FEED, 32'hAA);
		wr(`WWT_OFS_WARN, 32'h10);
		rc_chk("st_seq", `WWT_OFS_STATUS, 32'h4);
		rc_chk("mode_seq", `WWT_OFS_MODE, 32'h6);
		wr(`WWT_OFS_MODE, 32'h1);
		wr(`WWT_OFS_FEED, 32'h12);
		rc_chk("mode_flag", `WWT_OFS_MODE, 32'h10);
		chk("pulse_ferr", 32'h1, pulses);
		wr(`WWT_OFS_MODE, 32'h10);
		rc_chk("flag_clear", `WWT_OFS_MODE, 32'h0);
		rc_on <= 1'h0;
		osc_on <= 1'h1;
		wr(`WWT_OFS_MODE, 32'h9);
		t0 = cyc;
		do @(posedge aclk); while (wd_chip_reset !== 1'h1);
		chk("tout_time", 32'h1, cyc - t0 >= 16300 && cyc - t0 <= 16500);
		rc_chk("mode_osc", `WWT_OFS_MODE, 32'h18);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rc_chk("mode_rst", `WWT_OFS_MODE, 32'h0);
		final_report;
	end
endmodule

/* File: wwt_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the watchdog
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: Byte addresses
`ifndef WWT_MAP_SVH
`define WWT_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define WWT_OFS_MODE 5'h00
`define WWT_OFS_TIMEOUT 5'h04
`define WWT_OFS_FEED 5'h08
`define WWT_OFS_COUNT 5'h0C
`define WWT_OFS_WARN 5'h10
`define WWT_OFS_WINDOW 5'h14
`define WWT_OFS_STATUS 5'h18
`define WWT_OFS_MASK 5'h1C

// ****************************************
// Mode fields
// ****************************************
`define WWT_MODE_EN 0
`define WWT_MODE_INT 1
`define WWT_MODE_WIN 2
`define WWT_MODE_CSEL 3
`define WWT_MODE_WDFLAG 4

// ****************************************
// Status fields
// ****************************************
`define WWT_ST_WARN 0
`define WWT_ST_TOUT 1
`define WWT_ST_FERR 2

// ****************************************
// Values and counts
// ****************************************
`define WWT_TIMEOUT_RST 24'hFFFFFF
`define WWT_TIMEOUT_MIN 24'h000100
`define WWT_WINDOW_RST 24'hFFFFFF
`define WWT_WARN_RST 24'h000000
`define WWT_FEED_FIRST 8'hAA
`define WWT_FEED_SECOND 8'h55
`define WWT_PRESCALE_LAST 2'h3
`define WWT_RESP_OKAY 2'h0
`define WWT_RESP_SLVERR 2'h2

`endif

/* File: wwt_pkg.sv */
// Purpose: Types shared by the watchdog
// Assumes: Nothing
// Notes: Constants live in wwt_map.svh
package wwt_pkg;

	// Control bits held in the mode register
	typedef struct packed {
		logic clk_sel;
		logic window_en;
		logic int_mode;
		logic enable;
	} wwt_ctrl_t;

	// Sticky event bits
	typedef struct packed {
		logic feed_err;
		logic timeout;
		logic warn;
	} wwt_evt_t;

	// Feed sequence progress
	typedef enum logic {
		WWT_FEED_IDLE,
		WWT_FEED_ARMED
	} wwt_feed_t;

endpackage

/* File: wwt_top.sv */
// Purpose: Windowed watchdog timer with AXI4-Lite register access
// Assumes: aclk 20 MHz; count clocks much slower than aclk
// Notes: Count clock pins are synchronised and edge detected
//
// How it works
// [R1] Counter reaching zero while enabled pulses a chip reset, or interrupts in interrupt mode.
// [R2] With window on, feeds count only once counter is at or below window.
// [R3] Warning status sets when the counter decrements onto the warning value.
// [R4] Enable is set by software only; reset or watchdog event clears it.
// [R5] Wrong feed sequence resets chip, or interrupts in interrupt mode.
// [R6] A readable flag records that the watchdog reset the chip.
// [R7] Programmable 24-bit counter stepped through a divide-by-4 prescaler.
// [R8] Time-out spans 256*4 to (2^24-1)*4 count clock periods, in steps of 4.
// [R9] Count clock chosen between internal RC clock and dedicated oscillator.
// [R10] Accepted feed reloads the time-out; counter decrements per prescaled tick.
// [R11] Windowed feed before the window opens counts as a wrong feed.
`timescale 1ns/1ps
`include "wwt_map.svh"

module wwt_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Count clock pins
	input wire logic internal_rc_clock,
	input wire logic dedicated_wd_oscillator,
	// Write address channel
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// Write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address channel
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// Read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Chip reset request and interrupt
	output logic wd_chip_reset,
	output logic irq
);

	// ****************************************
	// Functions
	// ****************************************

	// Byte-lane merge of a write into a 32-bit word
	function automatic logic [31:0] wwt_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Word offset known to the register map
	function automatic logic wwt_mapped(input logic [4:0] a);
		return a[1:0] == 2'h0;
	endfunction

	// ****************************************
	// State
	// ****************************************
	wwt_pkg::wwt_ctrl_t ctrl;
	wwt_pkg::wwt_evt_t status;
	wwt_pkg::wwt_evt_t mask;
	wwt_pkg::wwt_feed_t feed_state;
	logic wd_flag;
	logic [23:0] timeout;
	logic [23:0] warn_val;
	logic [23:0] window;
	logic [23:0] count;
	logic [1:0] prescale;
	logic rc_s1, rc_s2, rc_s3;
	logic osc_s1, osc_s2, osc_s3;
	logic [4:0] aw_addr;
	logic aw_full;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_full;

	// ****************************************
	// Count clock sampling
	// ****************************************

	// Two-flop synchronisers plus one edge-detect flop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{rc_s1, rc_s2, rc_s3} <= 3'h0;
			{osc_s1, osc_s2, osc_s3} <= 3'h0;
		end else begin
			{rc_s1, rc_s2, rc_s3} <= {internal_rc_clock, rc_s1, rc_s2};
			{osc_s1, osc_s2, osc_s3} <= {dedicated_wd_oscillator, osc_s1, osc_s2};
		end
	end

	// Count clock select and prescaler
	wire rc_rise = rc_s2 & ~rc_s3;
	wire osc_rise = osc_s2 & ~osc_s3;
	wire cnt_edge = ctrl.clk_sel ? osc_rise : rc_rise; // [R9]
	wire pre_tick = ctrl.enable & cnt_edge & (prescale == `WWT_PRESCALE_LAST); // [R7]
	wire [23:0] count_dec = count - 24'h000001;

	// ****************************************
	// Bus decode
	// ****************************************

	// Write fires once address and data are both held
	wire wr_go = aw_full & w_full & ~s_axi_bvalid;
	wire wr_ok = wr_go & wwt_mapped(aw_addr);
	wire wr_mode = wr_ok & (aw_addr == `WWT_OFS_MODE);
	wire wr_tout = wr_ok & (aw_addr == `WWT_OFS_TIMEOUT);
	wire wr_feed = wr_ok & (aw_addr == `WWT_OFS_FEED);
	wire wr_warn = wr_ok & (aw_addr == `WWT_OFS_WARN);
	wire wr_win = wr_ok & (aw_addr == `WWT_OFS_WINDOW);
	wire wr_stat = wr_ok & (aw_addr == `WWT_OFS_STATUS);
	wire wr_mask = wr_ok & (aw_addr == `WWT_OFS_MASK);
	wire [31:0] wr_mode_v = wwt_merge({27'h0, wd_flag, ctrl}, w_data, w_strb);
	wire [31:0] wr_tout_v = wwt_merge({8'h00, timeout}, w_data, w_strb);
	wire [31:0] wr_warn_v = wwt_merge({8'h00, warn_val}, w_data, w_strb);
	wire [31:0] wr_win_v = wwt_merge({8'h00, window}, w_data, w_strb);
	wire [31:0] wr_stat_v = w_strb[0] ? w_data : 32'h00000000;
	wire [31:0] wr_mask_v = wwt_merge({29'h0, mask}, w_data, w_strb);

	// ****************************************
	// Feed and event decode
	// ****************************************

	// Feed sequence: first value, then second value, no other write between
	wire [7:0] feed_byte = w_data[7:0];
	wire feed_first = wr_feed & w_strb[0] & (feed_byte == `WWT_FEED_FIRST) &
		(feed_state == wwt_pkg::WWT_FEED_IDLE);
	wire feed_second = wr_feed & w_strb[0] & (feed_byte == `WWT_FEED_SECOND) &
		(feed_state == wwt_pkg::WWT_FEED_ARMED);
	wire feed_bad_seq = wr_ok & ~feed_first & ~feed_second &
		(wr_feed | (feed_state == wwt_pkg::WWT_FEED_ARMED));
	wire in_window = ~ctrl.window_en | (count <= window); // [R2]
	wire feed_ok = ctrl.enable & feed_second & in_window; // [R10]
	wire feed_err = ctrl.enable & (feed_bad_seq | (feed_second & ~in_window)); // [R5] [R11]
	wire tout_hit = ctrl.enable & (count == 24'h000000); // [R1]
	wire wd_event = tout_hit | feed_err;
	wire warn_hit = pre_tick & ~tout_hit & (count_dec == warn_val); // [R3]

	// Status set terms, which win over a software clear
	wire [2:0] st_set = {feed_err & ctrl.int_mode, tout_hit & ctrl.int_mode, warn_hit};
	wire [2:0] next_status = (status & ~wr_stat_v[2:0] & {3{wr_stat}}) | (status & {3{~wr_stat}}) | st_set;

	// Time-out write, held at the shortest legal period
	wire [23:0] next_timeout = (wr_tout_v[23:0] < `WWT_TIMEOUT_MIN) ? `WWT_TIMEOUT_MIN : wr_tout_v[23:0]; // [R8]

	// ****************************************
	// Control registers
	// ****************************************

	// Mode, limits, mask and status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= '0;
			wd_flag <= 1'b0;
			timeout <= `WWT_TIMEOUT_RST;
			warn_val <= `WWT_WARN_RST;
			window <= `WWT_WINDOW_RST;
			mask <= '0;
			status <= '0;
		end else begin
			if (wd_event) begin
				ctrl.enable <= 1'b0; // [R4]
			end else if (wr_mode && wr_mode_v[`WWT_MODE_EN]) begin
				ctrl.enable <= 1'b1; // [R4]
			end
			if (wr_mode) begin
				ctrl.int_mode <= wr_mode_v[`WWT_MODE_INT];
				ctrl.window_en <= wr_mode_v[`WWT_MODE_WIN];
				ctrl.clk_sel <= wr_mode_v[`WWT_MODE_CSEL];
			end
			if (wd_event && !ctrl.int_mode) begin
				wd_flag <= 1'b1; // [R6]
			end else if (wr_mode && w_strb[0] && w_data[`WWT_MODE_WDFLAG]) begin
				wd_flag <= 1'b0;
			end
			if (wr_tout) begin
				timeout <= next_timeout;
			end
			if (wr_warn) begin
				warn_val <= wr_warn_v[23:0];
			end
			if (wr_win) begin
				window <= wr_win_v[23:0];
			end
			if (wr_mask) begin
				mask <= wr_mask_v[2:0];
			end
			status <= next_status;
		end
	end

	// ****************************************
	// Counter
	// ****************************************

	// Prescaler, reload and decrement
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prescale <= 2'h0;
			count <= `WWT_TIMEOUT_RST;
		end else begin
			if (!ctrl.enable || feed_ok) begin
				prescale <= 2'h0;
			end else if (cnt_edge) begin
				prescale <= prescale + 2'h1; // [R7]
			end
			if (!ctrl.enable || feed_ok || wd_event) begin
				count <= timeout; // [R10]
			end else if (pre_tick) begin
				count <= count_dec; // [R10]
			end
		end
	end

	// Feed sequence tracker
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			feed_state <= wwt_pkg::WWT_FEED_IDLE;
		end else begin
			case (feed_state)
				wwt_pkg::WWT_FEED_IDLE: begin
					if (feed_first) begin
						feed_state <= wwt_pkg::WWT_FEED_ARMED;
					end
				end
				wwt_pkg::WWT_FEED_ARMED: begin
					if (wr_ok) begin
						feed_state <= wwt_pkg::WWT_FEED_IDLE;
					end
				end
				default: begin
					feed_state <= wwt_pkg::WWT_FEED_IDLE;
				end
			endcase
		end
	end

	// Chip reset pulse and interrupt level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wd_chip_reset <= 1'b0;
			irq <= 1'b0;
		end else begin
			wd_chip_reset <= wd_event & ~ctrl.int_mode; // [R1] [R5]
			irq <= |(next_status & mask);
		end
	end

	// ****************************************
	// AXI4-Lite write side
	// ****************************************

	// Address and data held independently until the write fires
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 5'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `WWT_RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_full & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_full & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_full <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_full <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wwt_mapped(aw_addr) ? `WWT_RESP_OKAY : `WWT_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// AXI4-Lite read side
	// ****************************************

	// Read data selection
	wire [4:0] ra = s_axi_araddr;
	wire [31:0] rd_word =
		(ra == `WWT_OFS_MODE) ? {27'h0, wd_flag, ctrl} : // [R6]
		(ra == `WWT_OFS_TIMEOUT) ? {8'h00, timeout} :
		(ra == `WWT_OFS_COUNT) ? {8'h00, count} :
		(ra == `WWT_OFS_WARN) ? {8'h00, warn_val} :
		(ra == `WWT_OFS_WINDOW) ? {8'h00, window} :
		(ra == `WWT_OFS_STATUS) ? {29'h0, status} :
		(ra == `WWT_OFS_MASK) ? {29'h0, mask} : 32'h00000000;

	// One read at a time, answered the cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `WWT_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= wwt_mapped(ra) ? `WWT_RESP_OKAY : `WWT_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

/* File: wwt_top_checker.sv */
// Purpose: Port-level protocol and event checks of the watchdog
// Assumes: Master offers write address and data together
// Notes: Bound to wwt_top
`timescale 1ns/1ps
`include "wwt_map.svh"
module wwt_top_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write side
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read side
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Events
	input wire logic wd_chip_reset,
	input wire logic irq
);
	// ****************************************
	// Handshake decode
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic aw_t = s_axi_awvalid && s_axi_awready;
	wire logic w_t = s_axi_wvalid && s_axi_wready;
	wire logic ar_t = s_axi_arvalid && s_axi_arready;
	wire logic aw_bad = s_axi_awaddr[1:0] != 2'h0;
	wire logic ar_bad = s_axi_araddr[1:0] != 2'h0;
	chk_bresp_code: assert property (aw_t && w_t |-> ##2 s_axi_bvalid &&
		s_axi_bresp == ($past(aw_bad, 2) ? `WWT_RESP_SLVERR : `WWT_RESP_OKAY)) else $error("bad write answer");
	chk_ready_drop: assert property (aw_t |=> !s_axi_awready && !s_axi_wready) else $error("ready kept");
	chk_bvalid_cause: assert property ($rose(s_axi_bvalid) |-> $past(w_t, 2)) else $error("stray bvalid");
	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("bvalid dropped");
	chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rvalid dropped");
	chk_ar_answer: assert property (ar_t |=> s_axi_rvalid && !s_axi_arready &&
		s_axi_rresp == ($past(ar_bad) ? `WWT_RESP_SLVERR : `WWT_RESP_OKAY)) else $error("bad read answer");
	chk_misalign_zero: assert property (ar_t && ar_bad |=> s_axi_rdata == 32'h0) else $error("data on error");
	chk_reset_pulse: assert property (wd_chip_reset |=> !wd_chip_reset [*8]) else $error("long pulse");
	chk_irq_fall: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("irq lost");
	cov_reset: cover property (wd_chip_reset);
	cov_irq: cover property ($rose(irq));
	cov_bad_rd: cover property (ar_t && ar_bad);
endmodule
bind wwt_top wwt_top_checker u_wwt_top_checker (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wd_chip_reset(wd_chip_reset), .irq(irq));
